// >>> rtl/sideband_pkg.sv
// Purpose: shared constants of the processor sideband control block
// Assumes: 8-bit register address, 32-bit register data
// Notes:   register offsets are byte addresses of aligned words
package sideband_pkg;
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam int          SYNC_BITS     = 4;

   // register offsets
   localparam logic [7:0]  OFF_CTRL      = 8'h00;
   localparam logic [7:0]  OFF_VECTOR    = 8'h04;
   localparam logic [7:0]  OFF_STATUS    = 8'h08;

   // control register fields
   localparam int          CTRL_NE_BIT   = 0;
   localparam int          CTRL_APIC_BIT = 1;
   localparam logic        NE_RST        = 1'b0;
   localparam logic        APIC_RST      = 1'b1;
   localparam logic [31:0] VECTOR_RST    = 32'hFFFF_FFF0;

   // status register fields
   localparam int          ST_INTERNAL_ERROR_OUT_BIT   = 0;
   localparam int          ST_FPPEND_BIT = 1;
   localparam int          ST_BIST_BIT   = 2;
   localparam int          ST_LOCK_BIT   = 3;
   localparam int          ST_INIT_BIT   = 4;
   localparam int          ST_LOCKIN_BIT = 5;
   localparam int          ST_RATIO_LSB  = 8;

   // synchroniser bit positions
   localparam int          SY_INIT       = 0;
   localparam int          SY_LOCAL_INTERRUPT_PIN_ZERO      = 1;
   localparam int          SY_LOCAL_INTERRUPT_PIN_ONE      = 2;
   localparam int          SY_IGNORE_NUMERIC_ERROR_IN      = 3;

   // strap capture waits for both synchroniser stages to refill after reset
   localparam logic [1:0]  STRAP_WAIT    = 2'h2;
   localparam logic [1:0]  REL_DONE      = 2'h3;
endpackage : sideband_pkg

// >>> rtl/lock_if.sv
// Purpose: carries the locked-sequence signals between control and lock driver
// Assumes: single clock domain
// Notes:   lock pin is active low; oe_n low while driving
interface lock_if;
   logic seq_start;
   logic seq_last_end;
   logic lock_n;
   logic oe_n;
   logic active;

   modport drv  (input seq_start, input seq_last_end, output lock_n, output oe_n, output active);
   modport user (output seq_start, output seq_last_end, input lock_n, input oe_n, input active);
endinterface : lock_if

// >>> rtl/sync_bank.sv
// Purpose: two-flop synchronisers, one per asynchronous input bit
// Assumes: inputs are levels, held longer than two clocks to be seen
// Notes:   first stage feeds only the second stage
module sync_bank #(
   parameter int W = 4
) (
   input  wire logic         ref_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_r;
         logic s2_r;
         always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
            end else begin
               s1_r <= d[i];
               s2_r <= s1_r;
            end
         end
         assign q[i] = s2_r;
      end
   endgenerate
endmodule : sync_bank

// >>> rtl/lock_driver.sv
// Purpose: drives the bus-lock pin across a locked transaction sequence
// Assumes: start and last_end are one-cycle pulses from the bus sequencer
// Notes:   a new start in the cycle of a last_end keeps the lock held
module lock_driver (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   lock_if.drv       lk
);
   logic active_r;
   logic active_nxt;
   logic lock_n_r;
   logic oe_n_r;

   always_comb begin
      active_nxt = active_r;
      if (lk.seq_last_end) begin
         active_nxt = 1'b0;
      end
      if (lk.seq_start) begin
         active_nxt = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         active_r <= 1'b0;
         lock_n_r <= 1'b1;
         oe_n_r   <= 1'b1;
      end else begin
         active_r <= active_nxt;
         lock_n_r <= ~active_nxt;
         oe_n_r   <= ~active_nxt;
      end
   end

   // pin levels come from their own flops so no decode glitch reaches the shared wire
   assign lk.active = active_r;
   assign lk.lock_n = lock_n_r;
   assign lk.oe_n   = oe_n_r;
endmodule : lock_driver

// >>> rtl/processor_sideband_control.sv
// Purpose: sideband control and error pins: internal error, numeric error gating,
//          soft initialisation, local interrupts and bus lock
// Assumes: bus-initialise, fp and lock events are synchronous to ref_clk;
//          soft-init, ignore-numeric-error and local interrupts are asynchronous
// Notes:   registers reached over a plain strobe port, read data one cycle later

// Notes on behaviour
// - internal error detected drives the internal error output high
// - a new internal error also issues a shutdown request on the bus
// - ignore-numeric-error high lets pending numeric errors be skipped
// - ignore-numeric-error low raises exception on next noncontrol fp instruction
// - native numeric error bit set makes ignore-numeric-error irrelevant
// - ignore-numeric-error and local interrupts latched at reset release as ratio
// - soft-init resets integer registers, keeps caches and fp state
// - after soft-init fetching starts at the configured reset vector
// - snoop responses continue while soft-init is asserted
// - soft-init active at reset release starts built-in self-test
// - soft-init is treated as asynchronous to the bus clock
// - local interrupt controller off: pin zero maskable, pin one nonmaskable
// - local interrupt controller comes up enabled after reset
// - bus lock asserted from first transaction start to last transaction end
module processor_sideband_control (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        internal_error_detect,
   input  wire logic        bus_initialise_in,
   input  wire logic        soft_init_in,
   input  wire logic        ignore_numeric_error_in,
   input  wire logic [1:0]  local_interrupt_pins,
   input  wire logic        fp_error_event,
   input  wire logic        fp_noncontrol_issue,
   input  wire logic        lock_seq_start,
   input  wire logic        lock_seq_last_end,
   input  wire logic        bus_lock_n_in,
   output logic             internal_error_out,
   output logic             shutdown_req,
   output logic             fp_exception,
   output logic             fp_proceed,
   output logic             integer_reg_reset,
   output logic             fetch_start,
   output logic      [31:0] fetch_vector,
   output logic             snoop_respond,
   output logic             bist_start,
   output logic      [2:0]  ratio_strap,
   output logic             maskable_interrupt_request,
   output logic             nmi_request,
   output logic      [1:0]  apic_lint,
   output logic             bus_lock_n_out,
   output logic             bus_lock_oe_n
);
   logic [sideband_pkg::SYNC_BITS-1:0] async_in;
   logic [sideband_pkg::SYNC_BITS-1:0] sync_q;
   logic                               init_s;
   logic                               ignore_numeric_error_in_s;
   logic [1:0]                         lint_s;
   logic                               init_d_r;
   logic                               ne_r;
   logic                               apic_en_r;
   logic [31:0]                        vector_r;
   logic                               fp_pending_r;
   logic                               fp_pending_nxt;
   logic                               internal_error_out_nxt;
   logic                               internal_error_out_clear;
   logic [1:0]                         rel_cnt_r;
   logic                               strap_capture;
   logic                               bist_seen_r;
   logic                               fp_raise;
   logic [31:0]                        rdata_nxt;

   lock_if lk ();

   assign async_in = {ignore_numeric_error_in, local_interrupt_pins[1], local_interrupt_pins[0], soft_init_in};

   sync_bank #(.W(sideband_pkg::SYNC_BITS)) u_sync (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .d       (async_in),
      .q       (sync_q)
   );

   assign init_s  = sync_q[sideband_pkg::SY_INIT];
   assign ignore_numeric_error_in_s = sync_q[sideband_pkg::SY_IGNORE_NUMERIC_ERROR_IN];
   assign lint_s  = {sync_q[sideband_pkg::SY_LOCAL_INTERRUPT_PIN_ONE], sync_q[sideband_pkg::SY_LOCAL_INTERRUPT_PIN_ZERO]};

   lock_driver u_lock (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .lk      (lk)
   );

   assign lk.seq_start    = lock_seq_start;
   assign lk.seq_last_end = lock_seq_last_end;
   assign bus_lock_n_out  = lk.lock_n;
   assign bus_lock_oe_n   = lk.oe_n;

   // ---------------- register port ----------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ne_r      <= sideband_pkg::NE_RST;
         apic_en_r <= sideband_pkg::APIC_RST;
         vector_r  <= sideband_pkg::VECTOR_RST;
      end else if (reg_wr) begin
         if (reg_addr == sideband_pkg::OFF_CTRL) begin
            ne_r      <= reg_wdata[sideband_pkg::CTRL_NE_BIT];
            apic_en_r <= reg_wdata[sideband_pkg::CTRL_APIC_BIT];
         end
         if (reg_addr == sideband_pkg::OFF_VECTOR) begin
            vector_r <= reg_wdata;
         end
      end
   end

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (reg_addr)
         sideband_pkg::OFF_CTRL: begin
            rdata_nxt[sideband_pkg::CTRL_NE_BIT]   = ne_r;
            rdata_nxt[sideband_pkg::CTRL_APIC_BIT] = apic_en_r;
         end
         sideband_pkg::OFF_VECTOR: begin
            rdata_nxt = vector_r;
         end
         sideband_pkg::OFF_STATUS: begin
            rdata_nxt[sideband_pkg::ST_INTERNAL_ERROR_OUT_BIT]   = internal_error_out;
            rdata_nxt[sideband_pkg::ST_FPPEND_BIT] = fp_pending_r;
            rdata_nxt[sideband_pkg::ST_BIST_BIT]   = bist_seen_r;
            rdata_nxt[sideband_pkg::ST_LOCK_BIT]   = lk.active;
            rdata_nxt[sideband_pkg::ST_INIT_BIT]   = init_s;
            rdata_nxt[sideband_pkg::ST_LOCKIN_BIT] = ~bus_lock_n_in;
            rdata_nxt[sideband_pkg::ST_RATIO_LSB +: 3] = ratio_strap;
         end
         default: begin
            rdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ---------------- internal error ----------------
   assign internal_error_out_clear = bus_initialise_in | init_s;

   always_comb begin
      internal_error_out_nxt = internal_error_out;
      if (internal_error_out_clear) begin
         internal_error_out_nxt = 1'b0;
      end
      if (internal_error_detect) begin
         internal_error_out_nxt = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         internal_error_out <= 1'b0;
         shutdown_req       <= 1'b0;
      end else begin
         internal_error_out <= internal_error_out_nxt;
         shutdown_req       <= internal_error_detect & ~internal_error_out;
      end
   end

   // ---------------- numeric error gating ----------------
   // native mode ignores ignore_numeric_error_in
   assign fp_raise = fp_noncontrol_issue & fp_pending_r & (ne_r | ~ignore_numeric_error_in_s);

   always_comb begin
      fp_pending_nxt = fp_pending_r;
      if (fp_raise) begin
         fp_pending_nxt = 1'b0;
      end
      if (fp_error_event) begin
         fp_pending_nxt = 1'b1;
      end
   end

   // soft-init leaves fp state alone, so pending survives it
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fp_pending_r <= 1'b0;
         fp_exception <= 1'b0;
         fp_proceed   <= 1'b0;
      end else begin
         fp_pending_r <= fp_pending_nxt;
         fp_exception <= fp_raise;
         fp_proceed   <= fp_noncontrol_issue & ~fp_raise;
      end
   end

   // ---------------- reset-release straps ----------------
   // async reset cannot load pins, so straps are taken once the synchronisers refill
   assign strap_capture = (rel_cnt_r == sideband_pkg::STRAP_WAIT);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rel_cnt_r   <= 2'h0;
         ratio_strap <= 3'h0;
         bist_start  <= 1'b0;
         bist_seen_r <= 1'b0;
      end else begin
         if (rel_cnt_r != sideband_pkg::REL_DONE) begin
            rel_cnt_r <= rel_cnt_r + 2'h1;
         end
         bist_start <= 1'b0;
         if (strap_capture) begin
            ratio_strap <= {ignore_numeric_error_in_s, lint_s};
            bist_start  <= init_s;
            bist_seen_r <= init_s;
         end
      end
   end

   // ---------------- soft initialisation ----------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         init_d_r          <= 1'b0;
         integer_reg_reset <= 1'b0;
         fetch_start       <= 1'b0;
         fetch_vector      <= sideband_pkg::VECTOR_RST;
         snoop_respond     <= 1'b1;
      end else begin
         init_d_r          <= init_s;
         integer_reg_reset <= init_s & ~init_d_r;
         fetch_start       <= ~init_s & init_d_r;
         fetch_vector      <= vector_r;
         snoop_respond     <= 1'b1;
      end
   end

   // ---------------- local interrupts ----------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         maskable_interrupt_request <= 1'b0;
         nmi_request                <= 1'b0;
         apic_lint                  <= 2'h0;
      end else begin
         maskable_interrupt_request <= ~apic_en_r & lint_s[0];
         nmi_request                <= ~apic_en_r & lint_s[1];
         apic_lint                  <= apic_en_r ? lint_s : 2'h0;
      end
   end

   // ---------------- assertions ----------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   property p_internal_error_out_set;
      internal_error_detect |=> internal_error_out;
   endproperty
   a_internal_error_out_set: assert property (p_internal_error_out_set) else $error("internal error not raised");
   property p_internal_error_out_hold;
      internal_error_out && !bus_initialise_in && !init_s |=> internal_error_out;
   endproperty
   a_internal_error_out_hold: assert property (p_internal_error_out_hold) else $error("internal error dropped early");
   property p_shutdown;
      internal_error_detect && !internal_error_out |=> shutdown_req ##1 !shutdown_req;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("shutdown missing");
   property p_ignore;
      fp_noncontrol_issue && fp_pending_r && ignore_numeric_error_in_s && !ne_r |=> fp_proceed && !fp_exception;
   endproperty
   a_ignore: assert property (p_ignore) else $error("ignored error still raised");
   property p_fp_raise;
      fp_noncontrol_issue && fp_pending_r && !ignore_numeric_error_in_s |=> fp_exception && !fp_proceed;
   endproperty
   a_fp_raise: assert property (p_fp_raise) else $error("fp exception missing");
   property p_native;
      fp_noncontrol_issue && fp_pending_r && ne_r |=> fp_exception;
   endproperty
   a_native: assert property (p_native) else $error("native mode not honoured");
   property p_strap;
      strap_capture |=> ratio_strap == $past(sync_q[3:1]) && bist_start == $past(init_s);
   endproperty
   a_strap: assert property (p_strap) else $error("strap capture wrong");
   property p_int_reset;
      $rose(init_s) |=> integer_reg_reset ##1 !integer_reg_reset;
   endproperty
   a_int_reset: assert property (p_int_reset) else $error("integer reset pulse wrong");
   property p_fetch;
      $fell(init_s) |=> fetch_start && fetch_vector == $past(vector_r);
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch vector wrong");
   property p_snoop;
      init_s |-> snoop_respond;
   endproperty
   a_snoop: assert property (p_snoop) else $error("snoop stopped in soft-init");
   // soft-init passes both synchroniser stages, so init_s is checked one edge after the next
   property p_sync;
      soft_init_in && !sys_rst |=> ##1 init_s;
   endproperty
   a_sync: assert property (p_sync) else $error("soft-init latency not two");
   property p_lint;
      !apic_en_r && lint_s[0] |=> maskable_interrupt_request && apic_lint == 2'h0;
   endproperty
   a_lint: assert property (p_lint) else $error("maskable interrupt not routed");
   property p_lock;
      lock_seq_start |=> !bus_lock_n_out && !bus_lock_oe_n;
   endproperty
   a_lock: assert property (p_lock) else $error("lock not asserted");
   property p_lock_hold;
      !bus_lock_n_out && !lock_seq_last_end |=> !bus_lock_n_out;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock released early");
   c_internal_error_out_clear: cover property (internal_error_out ##1 !internal_error_out);
   c_fp_exc: cover property (fp_exception);
   c_bist: cover property (bist_start);
   c_lock_seq: cover property (lock_seq_start ##[1:20] lock_seq_last_end);
endmodule : processor_sideband_control

// >>> verification/core_logic_model.sv
// Purpose: system core logic and priority agent beside the sideband block
// Assumes: one clock; lock pin pulled up when nobody drives it
// Notes:   shutdown becomes a few cycles of nonmaskable request on pin one
module core_logic_model (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic shutdown_req,
   input  wire logic bus_lock_n_out,
   input  wire logic bus_lock_oe_n,
   input  wire logic priority_bus_request_req,
   output logic      ext_nmi,
   output logic      bus_lock_wire,
   output logic      prio_owned
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [2:0] nmi_cnt_r;

   // shutdown to nmi
   // held six cycles so the device synchroniser cannot miss it
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)
         nmi_cnt_r <= 3'h0;
      else if (shutdown_req)
         nmi_cnt_r <= 3'h6;
      else if (nmi_cnt_r != 3'h0)
         nmi_cnt_r <= nmi_cnt_r - 3'h1;
   end
   assign ext_nmi = (nmi_cnt_r != 3'h0);

   // released pin reads the pull-up level
   assign bus_lock_wire = bus_lock_oe_n ? 1'b1 : bus_lock_n_out;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)
         prio_owned <= 1'b0;
      else
         prio_owned <= priority_bus_request_req & bus_lock_wire;
   end
endmodule : core_logic_model

// >>> verification/processor_sideband_control_bench.sv
// Purpose: self-checking bench for the sideband control block
// Assumes: register port strobes one cycle, read data the cycle after
// Notes:   async pins are driven at the edge; latency counted in edges
module processor_sideband_control_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0, reg_rd = 1'b0;
   logic        internal_error_detect = 1'b0, bus_initialise_in = 1'b0;
   logic        soft_init_in = 1'b0, ignore_numeric_error_in = 1'b0;
   logic [1:0]  lint_tb = 2'h0;
   logic        fp_error_event = 1'b0, fp_noncontrol_issue = 1'b0;
   logic        lock_seq_start = 1'b0, lock_seq_last_end = 1'b0, priority_bus_request_req = 1'b0;
   logic [31:0] reg_rdata, fetch_vector;
   logic [2:0]  ratio_strap;
   logic [1:0]  apic_lint, local_interrupt_pins;
   logic        internal_error_out, shutdown_req, fp_exception, fp_proceed;
   logic        integer_reg_reset, fetch_start, snoop_respond, bist_start;
   logic        maskable_interrupt_request, nmi_request, bus_lock_n_out, bus_lock_oe_n;
   logic        bus_lock_n_in, ext_nmi, prio_owned, ok;
   logic [31:0] st;
   int          mismatches = 0;
   int          n_checks = 0;

   assign local_interrupt_pins = {lint_tb[1] | ext_nmi, lint_tb[0]};

   always #5 ref_clk = ~ref_clk;

   processor_sideband_control uut (.ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .internal_error_detect, .bus_initialise_in, .soft_init_in, .ignore_numeric_error_in,
      .local_interrupt_pins, .fp_error_event, .fp_noncontrol_issue, .lock_seq_start, .lock_seq_last_end,
      .bus_lock_n_in, .internal_error_out, .shutdown_req, .fp_exception, .fp_proceed, .integer_reg_reset,
      .fetch_start, .fetch_vector, .snoop_respond, .bist_start, .ratio_strap, .maskable_interrupt_request,
      .nmi_request, .apic_lint, .bus_lock_n_out, .bus_lock_oe_n);

   core_logic_model partner (.ref_clk, .sys_rst, .shutdown_req, .bus_lock_n_out, .bus_lock_oe_n, .priority_bus_request_req,
      .ext_nmi, .bus_lock_wire(bus_lock_n_in), .prio_owned);

   task automatic clk(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : clk

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      clk(1);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      clk(1);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      clk(1);
      reg_addr <= a;
      reg_rd <= 1'b1;
      clk(1);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      rd(a, d);
      chk(d, exp);
   endtask : rchk

   task automatic fp_err();
      clk(1);
      fp_error_event <= 1'b1;
      clk(1);
      fp_error_event <= 1'b0;
   endtask : fp_err

   task automatic fp_issue(input logic exc);
      clk(1);
      fp_noncontrol_issue <= 1'b1;
      clk(1);
      fp_noncontrol_issue <= 1'b0;
      #1 chk({fp_exception, fp_proceed}, exc ? 32'h2 : 32'h1);
   endtask : fp_issue

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim

   initial begin
      #200us;
      $display("Error %0t: timeout", $time);
      mismatches++;
      end_sim();
   end

   initial begin
      clk(6);
      sys_rst <= 1'b0;
      #1 chk(fetch_vector, 32'hFFFF_FFF0);
      chk({internal_error_out, snoop_respond, bus_lock_oe_n}, 32'h3);
      rchk(sideband_pkg::OFF_CTRL, 32'h2);
      rchk(sideband_pkg::OFF_VECTOR, 32'hFFFF_FFF0);
      rchk(8'h0C, 32'h0);
      clk(1);
      lint_tb <= 2'h3;
      clk(3);
      #1 chk({apic_lint, maskable_interrupt_request, nmi_request}, 32'hC);
      clk(1);
      lint_tb <= 2'h0;
      $display("test reset and defaults done");

      // controller off so the partner's shutdown nmi shows on nmi_request
      wr(sideband_pkg::OFF_CTRL, 32'h0);
      clk(1);
      internal_error_detect <= 1'b1;
      clk(1);
      internal_error_detect <= 1'b0;
      #1 chk({internal_error_out, shutdown_req}, 32'h3);
      clk(1);
      internal_error_detect <= 1'b1;
      clk(1);
      internal_error_detect <= 1'b0;
      #1 chk({internal_error_out, shutdown_req}, 32'h2);
      ok = 1'b0;
      for (int i = 0; i < 8; i++) begin
         clk(1);
         #1 if (nmi_request === 1'b1) ok = 1'b1;
      end
      chk(ok, 32'h1);
      clk(12);
      #1 chk(internal_error_out, 32'h1);
      clk(1);
      bus_initialise_in <= 1'b1;
      clk(1);
      bus_initialise_in <= 1'b0;
      #1 chk(internal_error_out, 32'h0);
      for (int v = 1; v < 3; v++) begin
         clk(1);
         lint_tb <= v[1:0];
         clk(2);
         #1 chk({nmi_request, maskable_interrupt_request}, 32'h0);
         clk(1);
         #1 chk({apic_lint, nmi_request, maskable_interrupt_request}, v);
         // let the old level drain through the synchroniser before the next pin
         clk(1);
         lint_tb <= 2'h0;
         clk(3);
      end
      wr(sideband_pkg::OFF_CTRL, 32'h2);
      $display("test internal error and interrupts done");

      wr(sideband_pkg::OFF_VECTOR, 32'h1234_5670);
      internal_error_detect <= 1'b1;
      clk(1);
      internal_error_detect <= 1'b0;
      soft_init_in <= 1'b1;
      clk(2);
      #1 chk(integer_reg_reset, 32'h0);
      clk(1);
      #1 chk({integer_reg_reset, snoop_respond}, 32'h3);
      clk(1);
      #1 chk({integer_reg_reset, internal_error_out}, 32'h0);
      chk(snoop_respond, 32'h1);
      clk(1);
      soft_init_in <= 1'b0;
      clk(3);
      #1 chk(fetch_start, 32'h1);
      chk(fetch_vector, 32'h1234_5670);
      $display("test soft init done");

      fp_err();
      fp_issue(1'b1);
      fp_issue(1'b0);
      clk(1);
      ignore_numeric_error_in <= 1'b1;
      clk(3);
      fp_err();
      fp_issue(1'b0);
      fp_issue(1'b0);
      wr(sideband_pkg::OFF_CTRL, 32'h3);
      fp_issue(1'b1);
      wr(sideband_pkg::OFF_CTRL, 32'h2);
      ignore_numeric_error_in <= 1'b0;
      $display("test numeric error done");

      clk(1);
      priority_bus_request_req <= 1'b1;
      lock_seq_start <= 1'b1;
      clk(1);
      lock_seq_start <= 1'b0;
      #1 chk({bus_lock_n_out, bus_lock_oe_n}, 32'h0);
      clk(3);
      lock_seq_start <= 1'b1;
      lock_seq_last_end <= 1'b1;
      clk(1);
      lock_seq_start <= 1'b0;
      lock_seq_last_end <= 1'b0;
      #1 chk({bus_lock_n_out, prio_owned}, 32'h0);
      clk(1);
      lock_seq_last_end <= 1'b1;
      clk(1);
      lock_seq_last_end <= 1'b0;
      #1 chk({bus_lock_n_out, bus_lock_oe_n}, 32'h3);
      clk(1);
      #1 chk(prio_owned, 32'h1);
      clk(1);
      priority_bus_request_req <= 1'b0;
      $display("test bus lock done");

      sys_rst <= 1'b1;
      soft_init_in <= 1'b1;
      ignore_numeric_error_in <= 1'b1;
      lint_tb <= 2'h1;
      clk(3);
      sys_rst <= 1'b0;
      ok = 1'b0;
      for (int i = 0; i < 8; i++) begin
         clk(1);
         #1 if (bist_start === 1'b1) ok = 1'b1;
      end
      chk(ok, 32'h1);
      chk(ratio_strap, 32'h5);
      rd(sideband_pkg::OFF_STATUS, st);
      chk({st[10:8], st[2]}, 32'hB);
      clk(1);
      soft_init_in <= 1'b0;
      ignore_numeric_error_in <= 1'b0;
      lint_tb <= 2'h0;
      $display("test straps and self-test done");
      end_sim();
   end
endmodule : processor_sideband_control_bench
